// ### rtl/tdc_device.sv
// How it works
// - host holds reset during supply ramp
// - not ready until 47 ms after power-up
// - host recovers via sleep/cal or reset command
// - reset pulse of 90 ns resets device
// - ready 46.5 ms after reset release
// - soft reset ends after 194 ms, line released
// - reset-done flag set after every reset
// - checksum mismatch sets configuration error bit
// - change line released for 100 ms
// - calibrate on power-up, enable, command, config
// - detect beyond timeout forces recalibration
// - anti-touch delta without touches forces recalibration
// - messages at calibration start and end, global
// - burst then sleep, active or idle interval
// - objects start disabled until host enables
// - first touched object owns its group
// - objects may sit in several groups
// - key array internal suppression, one key wins
// - enabling suppression keeps existing detection
// - integrator counts above-threshold acquisitions, clears otherwise
// - change line only pulled low
`default_nettype none
module tdc_device #(
   parameter int unsigned N_CH = 8,
   parameter int unsigned N_GRP = 4,
   parameter int unsigned READY_PU_CYC = tdc_pkg::POWERUP_READY_CYC,
   parameter int unsigned READY_PIN_CYC = tdc_pkg::PIN_RESET_READY_CYC,
   parameter int unsigned SOFT_RST_CYC = tdc_pkg::SOFT_RESET_CYC,
   parameter int unsigned LINE_IN_CYC = tdc_pkg::LINE_INPUT_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   tdc_link_if.device link,
   input wire logic soft_reset_cmd,
   input wire logic recal_cmd,
   input wire logic cfg_changed,
   input wire logic [tdc_pkg::CFG_W-1:0] cfg_checksum,
   input wire logic [tdc_pkg::CFG_W-1:0] stored_checksum,
   input wire logic [N_CH-1:0] ch_enable,
   input wire logic [N_CH-1:0] ch_is_key,
   input wire logic [N_CH*N_GRP-1:0] ch_groups,
   input wire logic key_internal_supp,
   input wire logic supp_enable,
   input wire logic acq_valid,
   input wire logic [N_CH*tdc_pkg::SIG_W-1:0] ch_delta,
   input wire logic [N_CH-1:0] ch_anti,
   input wire logic [tdc_pkg::SIG_W-1:0] touch_threshold,
   input wire logic [7:0] integ_limit,
   input wire logic [tdc_pkg::CFG_W-1:0] detect_timeout_recal,
   input wire logic [tdc_pkg::CFG_W-1:0] active_cycle_interval,
   input wire logic [tdc_pkg::CFG_W-1:0] idle_cycle_interval,
   input wire logic [tdc_pkg::CFG_W-1:0] active_to_idle_timeout,
   input wire logic tick_ms,
   input wire logic msg_ack,
   output logic ready,
   output logic [7:0] msg_flags,
   output logic calibrating,
   output logic burst_start,
   output logic active_mode,
   output logic [N_CH-1:0] ch_detect
);
   initial
   begin
      if (N_CH < 1 || N_GRP < 1 || READY_PU_CYC < 1 || SOFT_RST_CYC < 1)
         $error("tdc_device: bad parameter");
   end
   typedef enum logic [2:0] {
      TDC_BOOT = 3'b001,
      TDC_RUN = 3'b010,
      TDC_SRST = 3'b100
   } tdc_st_t;
   typedef struct packed {
      tdc_st_t st;
      logic [1:0] rsync;
      logic rst_seen;
      logic [tdc_pkg::RESET_PULSE_CYC:0] low_cnt;
      logic pin_boot;
      logic [tdc_pkg::CNT_W-1:0] tmr;
      logic [tdc_pkg::CNT_W-1:0] line_tmr;
      logic line_rel;
      logic ready;
      logic [7:0] msg;
      logic cal;
      logic [N_CH-1:0] en_prev;
      logic [N_CH-1:0] det;
      logic [N_CH*8-1:0] integ;
      logic [N_CH*tdc_pkg::CFG_W-1:0] det_age;
      logic [tdc_pkg::CFG_W-1:0] cyc_cnt;
      logic [tdc_pkg::CFG_W-1:0] idle_cnt;
      logic active;
      logic burst;
      logic pend_oe;
   } tdc_state_t;
   tdc_state_t s_r, s_nxt;
   logic [N_CH-1:0] above;
   logic [N_CH-1:0] anti_hit;
   logic [N_CH-1:0] owned;
   logic [N_CH-1:0] age_hit;
   logic cal_trig;
   genvar g;
   generate
      for (g = 0; g < N_CH; g++)
      begin : g_ch
         logic [tdc_pkg::SIG_W-1:0] d;
         logic blk_grp;
         logic blk_key;
         assign d = ch_delta[g*tdc_pkg::SIG_W +: tdc_pkg::SIG_W];
         assign above[g] = ch_enable[g] && !ch_anti[g] && d > touch_threshold;
         assign anti_hit[g] = ch_enable[g] && ch_anti[g] && d >= touch_threshold;
         // blocked if any other detected channel shares a group with this one
         assign blk_grp = |(s_r.det & ~(N_CH'(1) << g) & group_peers(g));
         assign blk_key = ch_is_key[g] && key_internal_supp
                          && |(s_r.det & ch_is_key & ~(N_CH'(1) << g));
         // a channel already detecting keeps its detection: suppression blocks new ones only
         assign owned[g] = s_r.det[g] || !supp_enable || !(blk_grp || blk_key);
         assign age_hit[g] = s_r.det[g] && detect_timeout_recal != '0
            && s_r.det_age[g*tdc_pkg::CFG_W +: tdc_pkg::CFG_W] >= detect_timeout_recal;
      end
   endgenerate
   function automatic logic [N_CH-1:0] group_peers(input int unsigned ch);
      logic [N_CH-1:0] p;
      p = '0;
      for (int unsigned k = 0; k < N_CH; k++)
         p[k] = |(ch_groups[k*N_GRP +: N_GRP] & ch_groups[ch*N_GRP +: N_GRP]);
      return p;
   endfunction
   assign cal_trig = recal_cmd || cfg_changed
                     || |(ch_enable & ~s_r.en_prev)
                     || |age_hit
                     || (|anti_hit && s_r.det == '0);
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rsync = {s_r.rsync[0], link.reset_n_in};
      s_nxt.burst = 1'b0;
      if (msg_ack)
         s_nxt.msg = '0;
      if (s_r.line_tmr != '0)
         s_nxt.line_tmr = s_r.line_tmr - 1'b1;
      else
         s_nxt.line_rel = 1'b0;
      // short low pulses on the pin below the minimum are ignored
      if (!s_r.rsync[1])
      begin
         if (s_r.low_cnt != '1)
            s_nxt.low_cnt = s_r.low_cnt + 1'b1;
         if (s_r.low_cnt >= ($bits(s_r.low_cnt))'(tdc_pkg::RESET_PULSE_CYC))
            s_nxt.rst_seen = 1'b1;
      end
      else
      begin
         s_nxt.low_cnt = '0;
         if (s_r.rst_seen)
         begin
            s_nxt = '0;
            s_nxt.rsync = s_r.rsync;
            s_nxt.st = TDC_BOOT;
            s_nxt.pin_boot = 1'b1;
            // a pin reset restarts the input phase of the change line too
            s_nxt.line_rel = 1'b1;
            s_nxt.line_tmr = CNT_W_(LINE_IN_CYC);
         end
      end
      if (s_r.tmr != '0)
         s_nxt.tmr = s_r.tmr - 1'b1;
      case (s_r.st)
         TDC_BOOT:
         begin
            s_nxt.ready = 1'b0;
            if (s_r.tmr == '0 && !s_r.rst_seen)
            begin
               if (!s_r.cal && s_r.msg == '0)
               begin
                  s_nxt.tmr = s_r.pin_boot ? CNT_W_(READY_PIN_CYC) : CNT_W_(READY_PU_CYC);
                  s_nxt.cal = 1'b1;
                  s_nxt.msg = tdc_pkg::MSG_CAL_START;
               end
               else
               begin
                  s_nxt.st = TDC_RUN;
                  s_nxt.ready = 1'b1;
                  s_nxt.cal = 1'b0;
                  s_nxt.msg = s_r.msg | tdc_pkg::MSG_RESET_DONE | tdc_pkg::MSG_CAL_DONE;
                  if (cfg_checksum != stored_checksum)
                     s_nxt.msg[3] = 1'b1;
               end
            end
         end
         TDC_RUN:
         begin
            if (soft_reset_cmd)
            begin
               s_nxt.st = TDC_SRST;
               s_nxt.ready = 1'b0;
               s_nxt.tmr = CNT_W_(SOFT_RST_CYC);
               s_nxt.det = '0;
               s_nxt.integ = '0;
            end
            else
            begin
               s_nxt.cal = 1'b0;
               if (s_r.cal)
                  s_nxt.msg = s_nxt.msg | tdc_pkg::MSG_CAL_DONE;
               if (cal_trig)
               begin
                  // global calibration: every channel restarts together
                  s_nxt.cal = 1'b1;
                  s_nxt.msg = s_nxt.msg | tdc_pkg::MSG_CAL_START;
                  s_nxt.det = '0;
                  s_nxt.integ = '0;
                  s_nxt.det_age = '0;
               end
               else if (acq_valid)
               begin
                  for (int unsigned k = 0; k < N_CH; k++)
                  begin
                     if (!above[k])
                     begin
                        s_nxt.integ[k*8 +: 8] = '0;
                        s_nxt.det[k] = 1'b0;
                     end
                     else if (s_r.integ[k*8 +: 8] < integ_limit)
                        s_nxt.integ[k*8 +: 8] = s_r.integ[k*8 +: 8] + 8'h01;
                     else if (owned[k])
                        s_nxt.det[k] = 1'b1;
                  end
               end
               if (tick_ms)
                  for (int unsigned k = 0; k < N_CH; k++)
                     if (s_r.det[k])
                        s_nxt.det_age[k*tdc_pkg::CFG_W +: tdc_pkg::CFG_W] =
                           s_r.det_age[k*tdc_pkg::CFG_W +: tdc_pkg::CFG_W] + 1'b1;
                     else
                        s_nxt.det_age[k*tdc_pkg::CFG_W +: tdc_pkg::CFG_W] = '0;
               s_nxt.det = s_nxt.det & ch_enable;
               if (s_r.det != '0)
               begin
                  s_nxt.active = 1'b1;
                  s_nxt.idle_cnt = '0;
               end
               else if (tick_ms && s_r.active)
               begin
                  s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
                  if (s_r.idle_cnt >= active_to_idle_timeout)
                     s_nxt.active = 1'b0;
               end
               if (tick_ms)
               begin
                  s_nxt.cyc_cnt = s_r.cyc_cnt + 1'b1;
                  if (s_r.cyc_cnt >= (s_r.active ? active_cycle_interval : idle_cycle_interval))
                  begin
                     s_nxt.cyc_cnt = '0;
                     s_nxt.burst = 1'b1;
                  end
               end
            end
         end
         TDC_SRST:
         begin
            if (s_r.tmr == '0)
            begin
               s_nxt.st = TDC_BOOT;
               s_nxt.pin_boot = 1'b1;
               s_nxt.line_rel = 1'b1;
               s_nxt.line_tmr = CNT_W_(LINE_IN_CYC);
               s_nxt.msg = '0;
            end
         end
         default: s_nxt.st = TDC_BOOT;
      endcase
      s_nxt.en_prev = ch_enable;
      // drive low only when a message waits and the line is not in its input phase
      s_nxt.pend_oe = (s_nxt.msg != '0) && !s_nxt.line_rel;
   end
   function automatic logic [tdc_pkg::CNT_W-1:0] CNT_W_(input int unsigned v);
      return tdc_pkg::CNT_W'(v);
   endfunction
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_r <= '0;
         s_r.st <= TDC_BOOT;
         s_r.line_rel <= 1'b1;
         s_r.line_tmr <= tdc_pkg::CNT_W'(tdc_pkg::LINE_INPUT_CYC);
         s_r.rsync <= 2'b00;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
   assign link.pend_o = 1'b0;
   assign link.pend_oe = s_r.pend_oe;
   assign ready = s_r.ready;
   assign msg_flags = s_r.msg;
   assign calibrating = s_r.cal;
   assign burst_start = s_r.burst;
   assign active_mode = s_r.active;
   assign ch_detect = s_r.det;
endmodule : tdc_device
`default_nettype wire

// ### include/tdc_pkg.sv
`default_nettype none
package tdc_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   // times in their own units, as printed
   localparam int unsigned POWERUP_READY_US = 47_000;
   localparam int unsigned PIN_RESET_READY_US = 46_500;
   localparam int unsigned SOFT_RESET_US = 194_000;
   localparam int unsigned LINE_INPUT_US = 100_000;
   localparam int unsigned RESET_PULSE_NS = 90;
   // longest times round down, least times round up
   localparam int unsigned POWERUP_READY_CYC = POWERUP_READY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PIN_RESET_READY_CYC = PIN_RESET_READY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SOFT_RESET_CYC = SOFT_RESET_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LINE_INPUT_CYC = LINE_INPUT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned RESET_PULSE_CYC =
      (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned CFG_W = 16;
   localparam int unsigned SIG_W = 12;
   localparam logic [7:0] MSG_CAL_START = 8'h01;
   localparam logic [7:0] MSG_CAL_DONE = 8'h02;
   localparam logic [7:0] MSG_RESET_DONE = 8'h04;
   localparam logic [7:0] MSG_CFG_ERROR = 8'h08;
endpackage : tdc_pkg
`default_nettype wire

// ### include/tdc_link_if.sv
`default_nettype none
interface tdc_link_if;
   logic reset_n_o;
   logic reset_n_oe;
   logic pend_o;
   logic pend_oe;
   logic pend_in;
   logic reset_n_in;
   // open-drain line with pull-up: low only while someone drives low
   assign pend_in = !(pend_oe && !pend_o);
   assign reset_n_in = reset_n_oe ? reset_n_o : 1'b1;
   modport device (input reset_n_in, input pend_in, output pend_o, output pend_oe);
   modport host (output reset_n_o, output reset_n_oe, input pend_in);
endinterface : tdc_link_if
`default_nettype wire

// ### rtl/tdc_host.sv
`default_nettype none
module tdc_host #(
   parameter int unsigned PULSE_CYC = tdc_pkg::RESET_PULSE_CYC,
   parameter int unsigned WAIT_CYC = tdc_pkg::POWERUP_READY_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   tdc_link_if.host link,
   input wire logic supplies_good,
   input wire logic reset_req,
   output logic may_talk,
   output logic msg_pending
);
   initial
   begin
      if (PULSE_CYC < 1 || WAIT_CYC < 1)
         $error("tdc_host: bad parameter");
   end
   typedef enum logic [2:0] {
      TDH_HOLD = 3'b001,
      TDH_PULSE = 3'b010,
      TDH_WAIT = 3'b100
   } tdh_st_t;
   typedef struct packed {
      tdh_st_t st;
      logic [tdc_pkg::CNT_W-1:0] cnt;
      logic rst_low;
      logic may_talk;
      logic [1:0] psync;
      logic [1:0] gsync;
      logic pend;
   } tdh_state_t;
   tdh_state_t s_r, s_nxt;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.psync = {s_r.psync[0], link.pend_in};
      s_nxt.gsync = {s_r.gsync[0], supplies_good};
      s_nxt.pend = !s_r.psync[1] && s_r.may_talk;
      case (s_r.st)
         TDH_HOLD:
         begin
            s_nxt.rst_low = 1'b1;
            s_nxt.may_talk = 1'b0;
            if (s_r.gsync[1])
            begin
               s_nxt.st = TDH_PULSE;
               s_nxt.cnt = tdc_pkg::CNT_W'(PULSE_CYC);
            end
         end
         TDH_PULSE:
         begin
            if (s_r.cnt != '0)
               s_nxt.cnt = s_r.cnt - 1'b1;
            else
            begin
               s_nxt.rst_low = 1'b0;
               s_nxt.st = TDH_WAIT;
               s_nxt.cnt = tdc_pkg::CNT_W'(WAIT_CYC);
            end
         end
         TDH_WAIT:
         begin
            if (s_r.cnt != '0)
               s_nxt.cnt = s_r.cnt - 1'b1;
            else
               s_nxt.may_talk = 1'b1;
            // a reset is the recovery path when supplies were late
            if (reset_req || !s_r.gsync[1])
            begin
               s_nxt.st = s_r.gsync[1] ? TDH_PULSE : TDH_HOLD;
               s_nxt.rst_low = 1'b1;
               s_nxt.may_talk = 1'b0;
               s_nxt.cnt = tdc_pkg::CNT_W'(PULSE_CYC);
            end
         end
         default: s_nxt.st = TDH_HOLD;
      endcase
   end
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_r <= '0;
         s_r.st <= TDH_HOLD;
         s_r.rst_low <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
   // the host never drives the change line, it only watches it
   assign link.reset_n_o = !s_r.rst_low;
   assign link.reset_n_oe = 1'b1;
   assign may_talk = s_r.may_talk;
   assign msg_pending = s_r.pend;
endmodule : tdc_host
`default_nettype wire

// ### bench/tdc_assertions.sv
`default_nettype none
module tdc_assertions #(
   parameter int unsigned N_CH = 8,
   parameter int unsigned READY_CYC = 50,
   parameter int unsigned LINE_CYC = 30
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic pend_o,
   input wire logic pend_oe,
   input wire logic ready,
   input wire logic [7:0] msg_flags,
   input wire logic calibrating,
   input wire logic active_mode,
   input wire logic burst_start,
   input wire logic [N_CH-1:0] ch_detect,
   input wire logic [N_CH-1:0] ch_enable,
   input wire logic recal_cmd,
   input wire logic soft_reset_cmd,
   input wire logic acq_valid,
   input wire logic [N_CH*tdc_pkg::SIG_W-1:0] ch_delta,
   input wire logic [tdc_pkg::SIG_W-1:0] touch_threshold,
   input wire logic [tdc_pkg::CFG_W-1:0] cfg_checksum,
   input wire logic [tdc_pkg::CFG_W-1:0] stored_checksum
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // age since reset release; two cycles of slack cover the registered outputs
   logic [31:0] age_r;
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         age_r <= 32'h0;
      else if (age_r != 32'hffffffff)
         age_r <= age_r + 32'h1;
   property p_open_drain;
      pend_oe |-> !pend_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_line_input;
      age_r < 32'(LINE_CYC - 2) |-> !pend_oe;
   endproperty
   a_line_input: assert property (p_line_input) else $error("line driven early");
   property p_no_early;
      age_r < 32'(READY_CYC - 2) |-> !ready;
   endproperty
   a_no_early: assert property (p_no_early) else $error("ready too early");
   property p_reset_flag;
      $rose(ready) |-> msg_flags[2];
   endproperty
   a_reset_flag: assert property (p_reset_flag) else $error("no reset flag");
   property p_cfg_err;
      $rose(ready) |-> msg_flags[3] == (cfg_checksum != stored_checksum);
   endproperty
   a_cfg_err: assert property (p_cfg_err) else $error("config error bit wrong");
   property p_recal;
      ready && recal_cmd && !soft_reset_cmd && !calibrating
         |=> calibrating && msg_flags[0] ##1 !calibrating && msg_flags[1];
   endproperty
   a_recal: assert property (p_recal) else $error("recal sequence wrong");
   property p_soft;
      ready && soft_reset_cmd |=> !ready [*8];
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset kept ready");
   property p_integ;
      acq_valid && ch_delta[tdc_pkg::SIG_W-1:0] <= touch_threshold |=> !ch_detect[0];
   endproperty
   a_integ: assert property (p_integ) else $error("detect kept below threshold");
   property p_enable;
      ch_detect[0] |-> $past(ch_enable[0]);
   endproperty
   a_enable: assert property (p_enable) else $error("disabled channel detects");
   property p_active;
      ready && (|ch_detect) |-> ##[0:1] active_mode;
   endproperty
   a_active: assert property (p_active) else $error("touch without active mode");
   c_recal: cover property (recal_cmd ##1 calibrating);
   c_det: cover property ($rose(ch_detect[0]));
   c_burst: cover property (burst_start);
   c_soft: cover property (soft_reset_cmd ##1 !ready);
endmodule // tdc_assertions
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned N_CH = 8;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic soft_reset_cmd = 1'b0, recal_cmd = 1'b0, cfg_changed = 1'b0, msg_ack = 1'b0;
   logic [15:0] cfg_checksum = 16'h0, stored_checksum = 16'h1;
   logic [7:0] ch_enable = 8'h7f, ch_is_key = 8'h0, ch_anti = 8'h0, integ_limit = 8'h1;
   logic [31:0] ch_groups = 32'h0;
   logic key_internal_supp = 1'b0, supp_enable = 1'b0, acq_valid = 1'b0, tick_ms = 1'b0;
   logic [95:0] ch_delta = 96'h0;
   logic [11:0] touch_threshold = 12'h100;
   logic [15:0] detect_timeout_recal = 16'hffff, active_cycle_interval = 16'h1;
   logic [15:0] idle_cycle_interval = 16'h3, active_to_idle_timeout = 16'h2;
   logic supplies_good = 1'b0, reset_req = 1'b0;
   logic ready, calibrating, burst_start, active_mode, may_talk, msg_pending;
   logic [7:0] msg_flags, ch_detect;
   logic [7:0] q_msg[$];
   logic [7:0] q_det[$];
   logic rdy_q = 1'b0, cal_seen = 1'b0;
   logic [7:0] det_q = 8'h0;
   int bad_count = 0, total_checks = 0, cyc = 0, lim = 1;
   int bursts = 0, b0 = 0;
   tdc_link_if link ();
   tdc_device #(.READY_PU_CYC(50), .READY_PIN_CYC(40), .SOFT_RST_CYC(60), .LINE_IN_CYC(30))
   tdc_device_inst (.clk_sys, .arst_n, .link(link), .soft_reset_cmd, .recal_cmd, .cfg_changed,
      .cfg_checksum, .stored_checksum, .ch_enable, .ch_is_key, .ch_groups, .key_internal_supp,
      .supp_enable, .acq_valid, .ch_delta, .ch_anti, .touch_threshold, .integ_limit,
      .detect_timeout_recal, .active_cycle_interval, .idle_cycle_interval,
      .active_to_idle_timeout, .tick_ms, .msg_ack, .ready, .msg_flags, .calibrating,
      .burst_start, .active_mode, .ch_detect);
   tdc_host #(.WAIT_CYC(50)) tdc_host_inst (.clk_sys, .arst_n, .link(link), .supplies_good,
      .reset_req, .may_talk, .msg_pending);
   tdc_assertions #(.N_CH(8), .READY_CYC(50), .LINE_CYC(30)) tdc_assertions_inst (.clk_sys,
      .arst_n, .pend_o(link.pend_o), .pend_oe(link.pend_oe), .ready, .msg_flags, .calibrating,
      .active_mode, .burst_start, .ch_detect, .ch_enable, .recal_cmd, .soft_reset_cmd,
      .acq_valid, .ch_delta, .touch_threshold, .cfg_checksum, .stored_checksum);
   always #4 clk_sys = ~clk_sys;
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic end_sim();
      chk8(8'(q_msg.size() + q_det.size()), 8'h00);
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask
   task automatic wait_rdy(input logic lvl);
      int n;
      n = 0;
      while (ready !== lvl && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   // spacing of one idle cycle keeps acq_valid a clean pulse per acquisition
   task automatic acq(input logic [7:0] hot, input int reps);
      repeat (reps)
      begin
         for (int k = 0; k < N_CH; k++)
            ch_delta[k*12+:12] = hot[k] ? touch_threshold + 12'h1 + 12'($urandom_range(0, 200))
               : 12'($urandom_range(0, touch_threshold));
         acq_valid = 1'b1;
         @(negedge clk_sys);
         acq_valid = 1'b0;
         @(negedge clk_sys);
      end
   endtask
   always @(posedge clk_sys)
      if (calibrating)
         cal_seen <= 1'b1;
   always @(posedge clk_sys)
      if (burst_start)
         bursts <= bursts + 1;
   always @(negedge clk_sys)
   begin
      cyc++;
      tick_ms = (cyc % 8 == 0);
      if (cyc == 20000)
      begin
         bad_count++;
         end_sim();
      end
      if (arst_n && ready && !rdy_q)
         chk8(msg_flags & 8'h0e, q_msg.size() ? q_msg.pop_front() : 8'hff);
      if (arst_n && ch_detect !== det_q)
         chk8(ch_detect, q_det.size() ? q_det.pop_front() : 8'hff);
      rdy_q = ready;
      det_q = ch_detect;
   end
   initial
   begin
      void'($urandom(32'h318ed189));
      cfg_checksum = 16'($urandom);
      stored_checksum = cfg_checksum ^ 16'h0001;
      touch_threshold = 12'h100 + 12'($urandom_range(0, 'h300));
      lim = $urandom_range(1, 3);
      integ_limit = 8'(lim);
      active_cycle_interval = 16'($urandom_range(0, 3));
      idle_cycle_interval = 16'($urandom_range(0, 3));
      active_to_idle_timeout = 16'($urandom_range(1, 3));
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk1(link.reset_n_in, 1'b0);
      q_msg.push_back(8'h0e);
      supplies_good = 1'b1;
      wait_rdy(1'b1);
      chk1(ready, 1'b1);
      repeat (60) @(negedge clk_sys);
      chk1(may_talk, 1'b1);
      chk1(msg_pending, 1'b1);
      pulse(msg_ack);
      repeat (4) @(negedge clk_sys);
      chk8(msg_flags, 8'h00);
      chk1(msg_pending, 1'b0);
      for (int t = 0; t < 4; t++)
      begin
         cal_seen = 1'b0;
         case (t)
            0: pulse(recal_cmd);
            1: pulse(cfg_changed);
            2: ch_enable = 8'hff;
            default:
            begin
               ch_anti = 8'h01;
               ch_delta[11:0] = touch_threshold;
               pulse(acq_valid);
               ch_anti = 8'h00;
            end
         endcase
         repeat (5) @(negedge clk_sys);
         chk1(cal_seen, 1'b1);
      end
      pulse(msg_ack);
      q_det.push_back(8'h01);
      acq(8'h01, lim);
      acq(8'h00, 1);
      acq(8'h01, lim + 1);
      q_det.push_back(8'h00);
      acq(8'h00, 1);
      ch_groups = 32'h0000_0231;
      q_det.push_back(8'h03);
      acq(8'h03, lim + 1);
      supp_enable = 1'b1;
      acq(8'h03, 2);
      q_det.push_back(8'h01);
      acq(8'h01, 1);
      q_det.push_back(8'h05);
      acq(8'h07, lim + 1);
      q_det.push_back(8'h00);
      acq(8'h00, 1);
      ch_is_key = 8'h18;
      key_internal_supp = 1'b1;
      q_det.push_back(8'h08);
      acq(8'h08, lim + 1);
      acq(8'h18, lim + 1);
      q_det.push_back(8'h00);
      acq(8'h00, 1);
      repeat (50) @(negedge clk_sys);
      chk1(active_mode, 1'b0);
      // one idle period to settle, then a window of exactly three periods
      repeat (8 * (idle_cycle_interval + 1)) @(negedge clk_sys);
      b0 = bursts;
      repeat (24 * (idle_cycle_interval + 1)) @(negedge clk_sys);
      chk8(8'(bursts - b0), 8'h03);
      q_det.push_back(8'h01);
      acq(8'h01, lim + 1);
      cal_seen = 1'b0;
      q_det.push_back(8'h00);
      detect_timeout_recal = 16'h0002;
      repeat (40) @(negedge clk_sys);
      chk1(cal_seen, 1'b1);
      detect_timeout_recal = 16'hffff;
      pulse(msg_ack);
      stored_checksum = cfg_checksum;
      q_msg.push_back(8'h06);
      pulse(soft_reset_cmd);
      chk1(ready, 1'b0);
      wait_rdy(1'b1);
      chk1(ready, 1'b1);
      repeat (4) @(negedge clk_sys);
      chk1(msg_pending, 1'b1);
      pulse(msg_ack);
      q_msg.push_back(8'h06);
      pulse(reset_req);
      wait_rdy(1'b0);
      chk1(ready, 1'b0);
      wait_rdy(1'b1);
      chk1(ready, 1'b1);
      repeat (4) @(negedge clk_sys);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
